// ---- rtl/encpd_pkg.sv ----
// Summary of operation
// - Position word A counts lines times two-to-n.
// - Word A is cyclic, relative and free-running.
// - Word A reads zero after power-up.
// - One line per sine/cosine signal period.
// - Word B content chosen by fixed priority.
// - Code 1 on any encoder fault.
// - Code 2 zero mark, code 3 parking abort.
// - Code 4 aborts reference mark search.
// - Code 5 aborts reference value retrieval.
// - Code 6 aborts flying measurement.
// - Code 7 aborts get measured value.
// - Code 8 aborts cyclic absolute value.
// - Absolute value scaled by its own fine bits.
// - Descriptor bits 0..2 give type and abilities.
// - Descriptor bits 3..28 follow profile definition.
// - Descriptor bits 29..31 give switch, interface, validity.
// - Status bit 15 set while error code active.
package encpd_pkg;
	// ************************************************************
	// Register map and fields.
	// ************************************************************
	localparam logic [7:0]  ADDR_FORMAT   = 8'h00;
	localparam logic [7:0]  ADDR_FMT_CFG  = 8'h04;
	localparam logic [7:0]  ADDR_CH_BASE  = 8'h10;
	localparam logic [7:0]  ADDR_CH_STEP  = 8'h10;
	localparam logic [3:0]  OFS_CTRL      = 4'h0;
	localparam logic [3:0]  OFS_STATUS    = 4'h4;
	localparam logic [3:0]  OFS_WORD_A    = 4'h8;
	localparam logic [3:0]  OFS_WORD_B    = 4'hc;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] FMT_CFG_RESET = 32'h0000_0000;
	localparam int          FMT_LINEAR    = 0;
	localparam int          FMT_FINE_OK   = 1;
	localparam int          FMT_WIDE64    = 2;
	localparam int          FMT_PROF_LO   = 3;
	localparam int          FMT_PROF_HI   = 28;
	localparam int          FMT_NO_SWITCH = 29;
	localparam int          FMT_IF_DONE   = 30;
	localparam int          FMT_SUB_VALID = 31;
	localparam int          STS_ABS_ACK   = 13;
	localparam int          STS_PARK_ENC  = 14;
	localparam int          STS_FAULT     = 15;
	localparam int          FINE_W        = 16;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	localparam logic [3:0]  CODE_NONE     = 4'h0;
	localparam logic [3:0]  CODE_FAULT    = 4'h1;
	localparam logic [3:0]  CODE_ZMARK    = 4'h2;
	localparam logic [3:0]  CODE_PARK     = 4'h3;
	localparam logic [3:0]  CODE_REFSRCH  = 4'h4;
	localparam logic [3:0]  CODE_REFVAL   = 4'h5;
	localparam logic [3:0]  CODE_FLYING   = 4'h6;
	localparam logic [3:0]  CODE_MEASVAL  = 4'h7;
	localparam logic [3:0]  CODE_ABS      = 4'h8;

	// ************************************************************
	// Channel control register layout, MSB first.
	// ************************************************************
	typedef struct packed {
		logic [5:0] spare;
		logic [1:0] refMarkSel;
		logic       absEncAvail;
		logic       probeCfg;
		logic       hasZeroMark;
		logic       parkReq;
		logic       absCyclic;
		logic       fetchMeas;
		logic       fetchRef;
		logic [4:0] valueSel;
		logic       flying;
		logic       refSearch;
		logic [4:0] fineResBitsAbsolute;
		logic [4:0] fineResBitsRelative;
	} encpd_ctrl_t;

	// Encoder-side inputs of one channel, all on core_clk.
	typedef struct packed {
		logic        fault;
		logic        zeroMarkErr;
		logic        parkDoSelected;
		logic        distInconsistent;
		logic        absAlarm;
		logic        parkEncActive;
		logic        parkDoActive;
		logic [3:0]  refAvail;
		logic        measAvail;
		logic [31:0] lineCount;
		logic [15:0] finePhase;
		logic [31:0] absLines;
		logic [31:0] refValue;
		logic [31:0] measValue;
	} encpd_enc_t;

	typedef struct packed {
		logic [15:0] status;
		logic [31:0] wordA;
		logic [31:0] wordB;
	} encpd_out_t;
endpackage : encpd_pkg

// ---- rtl/encpd_top.sv ----
`timescale 1ns/1ps
module encpd_top #(
	parameter int NCH = 2
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   cycleTick,
	input  wire encpd_pkg::encpd_enc_t  enc [NCH],
	output encpd_pkg::encpd_out_t       chOut [NCH],
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	// ************************************************************
	// Helpers.
	// ************************************************************
	function automatic logic [31:0] scalePos(input logic [31:0] lines, input logic [15:0] fine,
		input logic [4:0] nBits);
		logic [4:0] n;
		n = (nBits > 5'd16) ? 5'd16 : nBits;
		scalePos = (lines << n) | 32'(fine >> (5'd16 - n));
	endfunction : scalePos

	function automatic logic [2:0] popCount(input logic [4:0] v);
		popCount = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
	endfunction : popCount

	// Channel register address decode; returns channel and offset validity.
	function automatic logic chHit(input logic [7:0] a, input int ch, input logic [3:0] ofs);
		chHit = (a == 8'(encpd_pkg::ADDR_CH_BASE + 8'(ch) * encpd_pkg::ADDR_CH_STEP + 8'(ofs)));
	endfunction : chHit

	// ************************************************************
	// Register bus state.
	// ************************************************************
	logic [7:0]           awAddr_r, awAddr_nxt;
	logic                 awHave_r, awHave_nxt;
	logic [31:0]          wData_r, wData_nxt;
	logic [3:0]           wStrb_r, wStrb_nxt;
	logic                 wHave_r, wHave_nxt;
	logic                 bValid_r, bValid_nxt;
	logic [1:0]           bResp_r, bResp_nxt;
	logic                 rValid_r, rValid_nxt;
	logic [1:0]           rResp_r, rResp_nxt;
	logic [31:0]          rData_r, rData_nxt;
	logic [31:0]          fmtCfg_r, fmtCfg_nxt;
	encpd_pkg::encpd_ctrl_t ctrl_r [NCH];
	encpd_pkg::encpd_ctrl_t ctrl_nxt [NCH];
	logic [31:0]          formatWord;
	logic                 doWrite;

	assign s_axi_awready = !awHave_r && !bValid_r;
	assign s_axi_wready  = !wHave_r && !bValid_r;
	assign s_axi_arready = !rValid_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rresp   = rResp_r;
	assign s_axi_rdata   = rData_r;
	assign doWrite       = awHave_r && wHave_r;

	// Fine resolution is always offered and 64-bit words never are.
	always_comb begin
		formatWord = fmtCfg_r;
		formatWord[encpd_pkg::FMT_FINE_OK] = 1'b1;
		formatWord[encpd_pkg::FMT_WIDE64]  = 1'b0;
	end

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			old[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
		end
		mergeBytes = old;
	endfunction : mergeBytes

	always_comb begin
		logic hit;
		logic [31:0] rd;
		hit         = 1'b0;
		rd          = 32'h0000_0000;
		awAddr_nxt  = awAddr_r;
		awHave_nxt  = awHave_r;
		wData_nxt   = wData_r;
		wStrb_nxt   = wStrb_r;
		wHave_nxt   = wHave_r;
		bValid_nxt  = bValid_r;
		bResp_nxt   = bResp_r;
		rValid_nxt  = rValid_r;
		rResp_nxt   = rResp_r;
		rData_nxt   = rData_r;
		fmtCfg_nxt  = fmtCfg_r;
		ctrl_nxt    = ctrl_r;
		if (s_axi_awvalid && s_axi_awready) begin
			awAddr_nxt = s_axi_awaddr;
			awHave_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
			wHave_nxt = 1'b1;
		end
		if (doWrite) begin
			if (awAddr_r == encpd_pkg::ADDR_FMT_CFG) begin
				hit        = 1'b1;
				fmtCfg_nxt = mergeBytes(fmtCfg_r, wData_r, wStrb_r);
			end
			for (int c = 0; c < NCH; c++) begin
				if (chHit(awAddr_r, c, encpd_pkg::OFS_CTRL)) begin
					hit         = 1'b1;
					ctrl_nxt[c] = mergeBytes(ctrl_r[c], wData_r, wStrb_r);
				end
			end
			awHave_nxt = 1'b0;
			wHave_nxt  = 1'b0;
			bValid_nxt = 1'b1;
			bResp_nxt  = hit ? encpd_pkg::RESP_OKAY : encpd_pkg::RESP_SLVERR;
		end else if (bValid_r && s_axi_bready) begin
			bValid_nxt = 1'b0;
		end
		hit = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			if (s_axi_araddr == encpd_pkg::ADDR_FORMAT) begin
				hit = 1'b1;
				rd  = formatWord;
			end
			if (s_axi_araddr == encpd_pkg::ADDR_FMT_CFG) begin
				hit = 1'b1;
				rd  = fmtCfg_r;
			end
			for (int c = 0; c < NCH; c++) begin
				if (chHit(s_axi_araddr, c, encpd_pkg::OFS_CTRL)) begin
					hit = 1'b1;
					rd  = ctrl_r[c];
				end
				if (chHit(s_axi_araddr, c, encpd_pkg::OFS_STATUS)) begin
					hit = 1'b1;
					rd  = {16'h0000, chOut[c].status};
				end
				if (chHit(s_axi_araddr, c, encpd_pkg::OFS_WORD_A)) begin
					hit = 1'b1;
					rd  = chOut[c].wordA;
				end
				if (chHit(s_axi_araddr, c, encpd_pkg::OFS_WORD_B)) begin
					hit = 1'b1;
					rd  = chOut[c].wordB;
				end
			end
			rValid_nxt = 1'b1;
			rData_nxt  = rd;
			rResp_nxt  = hit ? encpd_pkg::RESP_OKAY : encpd_pkg::RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			rValid_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awAddr_r <= 8'h00;
			awHave_r <= 1'b0;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
			wHave_r  <= 1'b0;
			bValid_r <= 1'b0;
			bResp_r  <= 2'b00;
			rValid_r <= 1'b0;
			rResp_r  <= 2'b00;
			rData_r  <= 32'h0000_0000;
			fmtCfg_r <= encpd_pkg::FMT_CFG_RESET;
			for (int c = 0; c < NCH; c++) begin
				ctrl_r[c] <= encpd_pkg::CTRL_RESET;
			end
		end else begin
			awAddr_r <= awAddr_nxt;
			awHave_r <= awHave_nxt;
			wData_r  <= wData_nxt;
			wStrb_r  <= wStrb_nxt;
			wHave_r  <= wHave_nxt;
			bValid_r <= bValid_nxt;
			bResp_r  <= bResp_nxt;
			rValid_r <= rValid_nxt;
			rResp_r  <= rResp_nxt;
			rData_r  <= rData_nxt;
			fmtCfg_r <= fmtCfg_nxt;
			ctrl_r   <= ctrl_nxt;
		end
	end

	// ************************************************************
	// Encoder channels; each one is identical.
	// ************************************************************
	encpd_pkg::encpd_out_t out_r [NCH];
	encpd_pkg::encpd_out_t out_nxt [NCH];
	logic [31:0]           base_r [NCH];
	logic [31:0]           base_nxt [NCH];
	logic                  based_r, based_nxt;
	logic [3:0]            code [NCH];
	logic [31:0]           rawPos [NCH];

	assign chOut = out_r;

	always_comb begin
		encpd_pkg::encpd_ctrl_t k;
		encpd_pkg::encpd_enc_t e;
		logic [2:0] nSel;
		logic [31:0] wb;
		k         = encpd_pkg::CTRL_RESET;
		e         = '0;
		nSel      = 3'd0;
		wb        = 32'h0000_0000;
		out_nxt   = out_r;
		base_nxt  = base_r;
		based_nxt = based_r || cycleTick;
		for (int c = 0; c < NCH; c++) begin
			k = ctrl_r[c];
			e = enc[c];
			nSel = popCount(k.valueSel);
			// The line count already advances once per sine period upstream.
			rawPos[c] = scalePos(e.lineCount, e.finePhase, k.fineResBitsRelative);
			// Fixed priority: lower code wins over every higher one.
			if (e.fault) code[c] = encpd_pkg::CODE_FAULT;
			else if (e.zeroMarkErr) code[c] = encpd_pkg::CODE_ZMARK;
			else if (k.parkReq && e.parkDoSelected) code[c] = encpd_pkg::CODE_PARK;
			else if (k.refSearch && (!k.hasZeroMark || k.refMarkSel != 2'd0 || k.flying
				|| k.valueSel != 5'd0 || e.distInconsistent)) code[c] = encpd_pkg::CODE_REFSRCH;
			else if (k.fetchRef && (nSel == 3'd0 || k.valueSel[4]
				|| (k.valueSel[3:0] & ~e.refAvail) != 4'h0)) code[c] = encpd_pkg::CODE_REFVAL;
			else if (k.flying && (!k.probeCfg || k.refSearch || k.valueSel != 5'd0))
				code[c] = encpd_pkg::CODE_FLYING;
			else if (k.fetchMeas && (nSel != 3'd1 || !e.measAvail || e.parkEncActive
				|| e.parkDoActive)) code[c] = encpd_pkg::CODE_MEASVAL;
			else if (k.absCyclic && (!k.absEncAvail || e.absAlarm))
				code[c] = encpd_pkg::CODE_ABS;
			else code[c] = encpd_pkg::CODE_NONE;
			if (code[c] != encpd_pkg::CODE_NONE) wb = 32'(code[c]);
			else if (k.fetchRef) wb = e.refValue;
			else if (k.fetchMeas) wb = e.measValue;
			else if (k.absCyclic)
				wb = scalePos(e.absLines, e.finePhase, k.fineResBitsAbsolute);
			else wb = 32'h0000_0000;
			// Values are published only at the telegram cycle, never in between.
			if (cycleTick) begin
				if (!based_r) base_nxt[c] = rawPos[c];
				// Plain subtraction wraps freely; overflow is left to the master.
				out_nxt[c].wordA = based_r ? rawPos[c] - base_r[c] : 32'h0000_0000;
				out_nxt[c].wordB = wb;
				out_nxt[c].status = 16'h0000;
				out_nxt[c].status[encpd_pkg::STS_FAULT] = code[c] != encpd_pkg::CODE_NONE;
				out_nxt[c].status[encpd_pkg::STS_PARK_ENC] = e.parkEncActive;
				out_nxt[c].status[encpd_pkg::STS_ABS_ACK] = k.absCyclic && !k.fetchRef
					&& !k.fetchMeas && code[c] == encpd_pkg::CODE_NONE;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			based_r <= 1'b0;
			for (int c = 0; c < NCH; c++) begin
				out_r[c]  <= '0;
				base_r[c] <= 32'h0000_0000;
			end
		end else begin
			based_r <= based_nxt;
			out_r   <= out_nxt;
			base_r  <= base_nxt;
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	a_first_pos_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycleTick && !based_r) |=> out_r[0].wordA == 32'h0000_0000)
		else $error("word A not zero at first cycle");
	a_pos_relative: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycleTick && based_r) |=> out_r[0].wordA == $past(rawPos[0]) - base_r[0])
		else $error("word A not relative to start");
	a_pos_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cycleTick |=> $stable(out_r[0].wordA) && $stable(out_r[1].wordB))
		else $error("words changed outside cycle");
	a_fault_code: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycleTick && enc[0].fault) |=> out_r[0].wordB == 32'h0000_0001)
		else $error("fault did not give code 1");
	a_zmark_code: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycleTick && !enc[1].fault && enc[1].zeroMarkErr) |=> out_r[1].wordB == 32'h0000_0002)
		else $error("zero mark error not code 2");
	a_status_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
		cycleTick |=> out_r[0].status[15] == (out_r[0].wordB[31:4] == 28'h0 && out_r[0].wordB != 0
			&& $past(code[0]) != 4'h0))
		else $error("status bit 15 disagrees with code");
	a_abs_code: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycleTick && code[0] == 4'h8) |=> out_r[0].wordB == 32'h0000_0008 && out_r[0].status[15])
		else $error("absolute abort not reported");
	a_fmt_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
		formatWord[2:1] == 2'b01 && formatWord[0] == fmtCfg_r[0])
		else $error("format fixed bits wrong");
	a_ch2_same: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cycleTick && enc[1].fault) |=> out_r[1].status[15] && out_r[1].wordB == 32'h0000_0001)
		else $error("channel 2 fault not reported");
endmodule : encpd_top

// ---- dv/encpd_master_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// Master controller side of the telegram.
// ************************************************************
// Widens each relative position word into a 64-bit running position.
// A whole word step in one telegram cycle would alias, so the master
// relies on the axis moving less than half a word between cycles.
module encpd_master_model #(
	parameter int NCH = 2
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   cycleTick,
	input  wire encpd_pkg::encpd_out_t  chOut [NCH],
	output logic [63:0]                 posExt [NCH]
);
	logic        tickSeen_r;
	logic [31:0] lastA_r [NCH];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickSeen_r <= 1'b0;
			for (int c = 0; c < NCH; c++) begin
				lastA_r[c] <= 32'h0;
				posExt[c] <= 64'h0;
			end
		end else begin
			tickSeen_r <= cycleTick;
			if (tickSeen_r) begin
				for (int c = 0; c < NCH; c++) begin
					lastA_r[c] <= chOut[c].wordA;
					posExt[c] <= posExt[c] + 64'(signed'(chOut[c].wordA - lastA_r[c]));
				end
			end
		end
	end
endmodule : encpd_master_model

// ---- dv/encoder_position_process_data_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin failCount++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module encoder_position_process_data_test;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [8:0]  flags;
		logic        err;
		logic [31:0] expB;
	} encpd_row_t;

	logic                  core_clk;
	logic                  rst_n;
	logic                  cycleTick;
	encpd_pkg::encpd_enc_t encIn [2];
	encpd_pkg::encpd_out_t chOut [2];
	logic [63:0]           posExt [2];
	logic [7:0]            s_axi_awaddr, s_axi_araddr;
	logic [31:0]           s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                  s_axi_rvalid, s_axi_rready;
	int                    failCount, samplesChecked, cycleCount;
	encpd_pkg::encpd_enc_t e;
	logic [31:0]           d, baseRaw;
	logic [1:0]            r;

	// Flags: fault, zero mark, park selected, distance, abs alarm, park enc,
	// park object, no reference value, no measured value.
	encpd_row_t rows [27] = '{
		'{32'h0000_0000, 9'h100, 1'b1, 32'h1},
		'{32'h0000_0000, 9'h080, 1'b1, 32'h2},
		'{32'h0010_0000, 9'h040, 1'b1, 32'h3},
		'{32'h0000_0400, 9'h000, 1'b1, 32'h4},
		'{32'h0120_0400, 9'h000, 1'b1, 32'h4},
		'{32'h0020_0c00, 9'h000, 1'b1, 32'h4},
		'{32'h0020_1400, 9'h000, 1'b1, 32'h4},
		'{32'h0020_0400, 9'h020, 1'b1, 32'h4},
		'{32'h0002_0000, 9'h000, 1'b1, 32'h5},
		'{32'h0003_0000, 9'h000, 1'b1, 32'h5},
		'{32'h0002_1000, 9'h002, 1'b1, 32'h5},
		'{32'h0000_0800, 9'h000, 1'b1, 32'h6},
		'{32'h0040_1800, 9'h000, 1'b1, 32'h6},
		'{32'h0004_0000, 9'h000, 1'b1, 32'h7},
		'{32'h0004_3000, 9'h000, 1'b1, 32'h7},
		'{32'h0004_1000, 9'h001, 1'b1, 32'h7},
		'{32'h0004_1000, 9'h008, 1'b1, 32'h7},
		'{32'h0004_1000, 9'h004, 1'b1, 32'h7},
		'{32'h0008_0000, 9'h000, 1'b1, 32'h8},
		'{32'h0088_0000, 9'h010, 1'b1, 32'h8},
		'{32'h0000_0000, 9'h180, 1'b1, 32'h1},
		'{32'h0002_0400, 9'h000, 1'b1, 32'h4},
		'{32'h0004_0800, 9'h000, 1'b1, 32'h6},
		'{32'h0002_1000, 9'h000, 1'b0, 32'hcafe_0001},
		'{32'h0004_1000, 9'h000, 1'b0, 32'h5eed_0002},
		'{32'h0088_0080, 9'h000, 1'b0, 32'h0001_234a},
		'{32'h0000_0000, 9'h000, 1'b0, 32'h0}
	};

	encpd_top #(.NCH(2)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .cycleTick(cycleTick), .enc(encIn), .chOut(chOut),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	encpd_master_model #(.NCH(2)) master (
		.core_clk(core_clk), .rst_n(rst_n), .cycleTick(cycleTick), .chOut(chOut), .posExt(posExt)
	);

	always #5 core_clk = ~core_clk;

	// ************************************************************
	// Bus and telegram tasks.
	// ************************************************************
	// Handshakes are sampled at the falling edge, where nothing moves,
	// so the outcome never depends on process order at the rising edge.
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ta, tw, tb;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ta, tr;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge core_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : axiRead

	task automatic setBoth(input logic [31:0] ctrl);
		axiWrite(8'h10, ctrl, r);
		axiWrite(8'h20, ctrl, r);
	endtask : setBoth

	task automatic setEnc(input encpd_pkg::encpd_enc_t v);
		@(posedge core_clk);
		encIn[0] <= v;
		encIn[1] <= v;
	endtask : setEnc

	// One extra cycle after the capture edge lets the master model catch up.
	task automatic tick;
		@(posedge core_clk);
		cycleTick <= 1'b1;
		@(posedge core_clk);
		cycleTick <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask : tick

	function automatic logic [31:0] raw3(input logic [31:0] l, input logic [15:0] f);
		return {l[28:0], 3'h0} | {29'h0, f[15:13]};
	endfunction : raw3

	task automatic printVerdict;
		$display("comparisons %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : printVerdict

	always @(posedge core_clk) begin
		cycleCount++;
		if (cycleCount == 5000) begin
			failCount++;
			$display("timeout after %0d cycles", cycleCount);
			printVerdict();
		end
	end

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		cycleTick = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		e = '0;
		e.refAvail = 4'h1;
		e.measAvail = 1'b1;
		e.refValue = 32'hcafe_0001;
		e.measValue = 32'h5eed_0002;
		e.absLines = 32'h0000_1234;
		encIn[0] = e;
		encIn[1] = e;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		`CHK("wordA", 32'h0, chOut[0].wordA)
		axiRead(8'h00, d, r);
		`CHK("format", 32'h0000_0002, d)
		axiRead(8'h10, d, r);
		`CHK("ctrl", encpd_pkg::CTRL_RESET, d)
		axiWrite(8'h04, 32'hffff_ffff, r);
		axiRead(8'h00, d, r);
		`CHK("format", 32'hffff_fffb, d)
		axiWrite(8'h04, 32'h6000_0001, r);
		axiRead(8'h00, d, r);
		`CHK("format", 32'h6000_0003, d)
		// Only byte lane 0 is written, so the upper lanes must keep their bits.
		@(posedge core_clk);
		s_axi_wstrb <= 4'h1;
		axiWrite(8'h04, 32'hffff_ffff, r);
		s_axi_wstrb <= 4'hf;
		axiRead(8'h00, d, r);
		`CHK("format", 32'h6000_00fb, d)
		axiRead(8'h08, d, r);
		`CHK("rresp", encpd_pkg::RESP_SLVERR, r)
		`CHK("rdata", 32'h0, d)
		axiWrite(8'h0c, 32'h1, r);
		`CHK("bresp", encpd_pkg::RESP_SLVERR, r)
		$display("test registers done");
		// Start just below a word boundary so the next step wraps.
		setBoth(32'h0000_0003);
		e.lineCount = 32'h1fff_fffe;
		e.finePhase = 16'h2000;
		baseRaw = raw3(e.lineCount, e.finePhase);
		setEnc(e);
		tick();
		for (int c = 0; c < 2; c++) `CHK("wordA", 32'h0, chOut[c].wordA)
		e.lineCount = 32'h2000_0001;
		e.finePhase = 16'he000;
		setEnc(e);
		tick();
		for (int c = 0; c < 2; c++) begin
			`CHK("wordA", raw3(e.lineCount, e.finePhase) - baseRaw, chOut[c].wordA)
			`CHK("posExt", 64'h1e, posExt[c])
		end
		axiRead(8'h18, d, r);
		`CHK("wordA reg", 32'h0000_001e, d)
		e.lineCount = 32'h1fff_fffd;
		e.finePhase = 16'h0000;
		setEnc(e);
		tick();
		`CHK("wordA", 32'hffff_fff7, chOut[1].wordA)
		`CHK("posExt", 64'hffff_ffff_ffff_fff7, posExt[0])
		$display("test position done");
		e.finePhase = 16'habcd;
		foreach (rows[i]) begin
			{e.fault, e.zeroMarkErr, e.parkDoSelected, e.distInconsistent, e.absAlarm,
				e.parkEncActive, e.parkDoActive} = rows[i].flags[8:2];
			e.refAvail = rows[i].flags[1] ? 4'h0 : 4'h1;
			e.measAvail = !rows[i].flags[0];
			setEnc(e);
			setBoth(rows[i].ctrl);
			tick();
			for (int c = 0; c < 2; c++) begin
				`CHK("wordB", rows[i].expB, chOut[c].wordB)
				`CHK("fault bit", rows[i].err, chOut[c].status[15])
			end
			if (i == 0) begin
				axiRead(8'h1c, d, r);
				`CHK("wordB reg", 32'h1, d)
				axiRead(8'h24, d, r);
				`CHK("status reg", 1'b1, d[15])
			end
		end
		$display("test codes done");
		// A standing fault keeps word B nonzero, so the reset must visibly clear it.
		e.fault = 1'b1;
		setEnc(e);
		tick();
		`CHK("wordB", 32'h1, chOut[1].wordB)
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		`CHK("wordA", 32'h0, chOut[1].wordA)
		`CHK("wordB", 32'h0, chOut[1].wordB)
		// The first cycle after a reset must take a fresh base again.
		tick();
		`CHK("wordA", 32'h0, chOut[0].wordA)
		`CHK("wordB", 32'h1, chOut[0].wordB)
		e.lineCount = 32'h2000_0002;
		setEnc(e);
		tick();
		`CHK("wordA", 32'h5, chOut[0].wordA)
		`CHK("posExt", 64'h5, posExt[1])
		$display("test second reset done");
		printVerdict();
	end
endmodule : encoder_position_process_data_test
